// File: rtl/diag_request_cmd.sv
// Diagnostic command interpreter with APB registers and byte link ports.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`include "diag_cmd_defines.svh"
`default_nettype none
module diag_request_cmd #(
    parameter int unsigned REQ_DEPTH     = 1024,
    parameter int unsigned RSP_DEPTH     = 1024,
    parameter logic [15:0] PAYLOAD_LIMIT = 16'h0100,
    parameter logic [7:0]  CHANNEL       = 8'h00,
    parameter logic [2:0]  J1939_PRIO    = 3'h6,
    parameter logic [7:0]  SOURCE_ADDR   = 8'hf9
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             tx_valid,
    output logic      [7:0]  tx_byte,
    output logic             tx_last,
    output logic      [28:0] tx_id,
    input  wire logic        tx_ready,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_last
);
    localparam int unsigned RAW = $clog2(REQ_DEPTH);
    localparam logic [16:0] REQ_CAP = 17'(REQ_DEPTH);

    diag_cmd_pkg::diag_state_t state_q;
    diag_cmd_pkg::cmd_state_t  cs_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        pop_hit_q;
    logic [15:0] len_q;
    logic [15:0] base_q;
    logic [15:0] cnt_q;
    logic [15:0] fill_q;
    logic        send_q;
    logic [7:0]  mode_q;
    logic        seg_q;
    logic        expect_q;
    logic        valid_q;
    logic [15:0] rsp_len_q;
    logic [7:0]  err_q;
    logic [23:0] pgn_q;
    logic        tx_valid_q;
    logic [7:0]  tx_byte_q;
    logic        tx_last_q;
    logic [28:0] tx_id_q;
    logic [15:0] tx_idx_q;
    logic [7:0]  rd_data;
    logic [7:0]  rsp_head;
    logic [15:0] rsp_count;
    logic        rsp_full;

    // Bus access decode; every transfer takes exactly one wait state.
    wire acc      = psel & penable;
    wire capture  = acc & ~pready_q;
    wire wr_fire  = acc & pwrite & pready_q;
    wire known    = (paddr == `OFS_CMD) | (paddr == `OFS_LEN) |
                    (paddr == `OFS_DATA) | (paddr == `OFS_STATUS) |
                    (paddr == `OFS_RSP_INFO) | (paddr == `OFS_RSP_DATA) |
                    (paddr == `OFS_CAN_ID);
    wire cmd_wr   = wr_fire & (paddr == `OFS_CMD);
    wire len_wr   = wr_fire & (paddr == `OFS_LEN);
    wire data_wr  = wr_fire & (paddr == `OFS_DATA);
    wire rsp_pop  = acc & ~pwrite & pready_q & pop_hit_q;

    // Command word fields.
    wire [7:0] c_op   = pwdata[7:0];
    wire [7:0] c_ch   = pwdata[15:8];
    wire [7:0] c_b1   = pwdata[23:16];
    wire       c_send = pwdata[`CMD_SEND_BIT];
    wire       c_cat  = pwdata[`CMD_CONCAT_BIT];
    wire       c_seg  = pwdata[`CMD_SEG_BIT];
    wire op_cfg   = (c_op == `OP_CONFIG);
    wire op_start = (c_op == `OP_START);
    wire op_send  = (c_op == `OP_SEND);
    wire op_read  = (c_op == `OP_READ);

    wire [15:0] start_max = PAYLOAD_LIMIT - `START_HDR;
    wire [15:0] send_max  = PAYLOAD_LIMIT - `SEND_HDR;
    wire [15:0] cat_base  = c_cat ? fill_q : 16'h0000;
    wire start_room = diag_cmd_pkg::fits(16'h0000, len_q, REQ_CAP);
    wire send_room  = diag_cmd_pkg::fits(cat_base, len_q, REQ_CAP);
    wire connected  = (state_q == diag_cmd_pkg::DS_CONNECTED);

    // A refused command leaves the buffer and the fill level untouched.
    wire [7:0] start_err =
        (state_q == diag_cmd_pkg::DS_NOT_INIT) ? `ERR_SEQ :
        ((len_q > start_max) | ~start_room)    ? `ERR_LEN : `ERR_NONE;
    wire [7:0] send_err =
        ~connected                              ? `ERR_SEQ :
        ((len_q == 16'h0000) | (len_q > send_max)) ? `ERR_LEN :
        ~send_room                              ? `ERR_OVF : `ERR_NONE;
    wire [7:0] cmd_err =
        (cs_q != diag_cmd_pkg::CS_IDLE) ? `ERR_BUSY :
        (c_ch != CHANNEL)               ? `ERR_CHAN :
        op_cfg                          ? `ERR_NONE :
        op_start                        ? start_err :
        op_send                         ? send_err :
        op_read                         ? `ERR_NONE : `ERR_OP;
    wire cmd_ok = cmd_wr & (cmd_err == `ERR_NONE);

    // Request byte collection.
    wire collect_wr = data_wr & (cs_q == diag_cmd_pkg::CS_COLLECT);
    wire [15:0] wr_pos   = base_q + cnt_q;
    wire [15:0] new_fill = wr_pos + 16'h0001;
    wire last_byte = collect_wr & ((cnt_q + 16'h0001) == len_q);
    wire tx_start  = last_byte & send_q;
    wire tx_hs     = tx_valid_q & tx_ready;
    wire [15:0] tx_next = tx_idx_q + 16'h0001;
    wire [RAW-1:0] rd_addr = tx_valid_q ? tx_next[RAW-1:0] : '0;
    // The first byte may be the one written in this very cycle.
    wire [7:0] first_byte = (wr_pos == 16'h0000) ? pwdata[7:0] : rd_data;

    // Group number bytes in message order, most significant first.
    wire [23:0] pgn_d;
    assign pgn_d[23:16] = (collect_wr & (wr_pos == 16'h0000)) ?
                          pwdata[7:0] : pgn_q[23:16];
    assign pgn_d[15:8]  = (collect_wr & (wr_pos == 16'h0001)) ?
                          pwdata[7:0] : pgn_q[15:8];
    assign pgn_d[7:0]   = (collect_wr & (wr_pos == 16'h0002)) ?
                          pwdata[7:0] : pgn_q[7:0];
    wire [28:0] id_d = {J1939_PRIO, pgn_d[17:0], SOURCE_ADDR};
    wire pgn_func = (pgn_q[15:8] >= `FUNC_PF_MIN);

    // Response intake: only while a sent request awaits its answer.
    wire rsp_push   = rx_valid & expect_q;
    wire rsp_end    = rsp_push & rx_last & ~rsp_full;
    wire rsp_clear  = cmd_ok & op_cfg & (c_b1 == 8'h00);
    wire busy       = (cs_q == diag_cmd_pkg::CS_SEND) | expect_q;
    wire [3:0] flags = {(rsp_count != 16'h0000), valid_q, busy, seg_q};

    wire [31:0] rd_mux =
        (paddr == `OFS_LEN)      ? {16'h0000, len_q} :
        (paddr == `OFS_STATUS)   ? {7'h00, pgn_func, err_q, 5'h00, state_q,
                                    4'h0, flags} :
        (paddr == `OFS_RSP_INFO) ? {rsp_count, rsp_len_q} :
        (paddr == `OFS_RSP_DATA) ? {24'h000000, rsp_head} :
        (paddr == `OFS_CAN_ID)   ? {3'h0, tx_id_q} : 32'h00000000;

    req_store #(
        .DEPTH   (REQ_DEPTH)
    ) u_req (
        .clk     (pclk),
        .wr_en   (collect_wr),
        .wr_addr (wr_pos[RAW-1:0]),
        .wr_data (pwdata[7:0]),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    rsp_queue #(
        .DEPTH     (RSP_DEPTH)
    ) u_rsp (
        .clk       (pclk),
        .rst_n     (presetn),
        .clear     (rsp_clear),
        .push      (rsp_push),
        .push_data (rx_byte),
        .pop       (rsp_pop),
        .head      (rsp_head),
        .count     (rsp_count),
        .full      (rsp_full)
    );

    // Bus answer registers; read data and the pop decision are taken
    // together so a byte arriving mid-transfer cannot skew them.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
            pop_hit_q <= 1'b0;
        end
        else
        begin
            pready_q  <= capture;
            pslverr_q <= capture & ~known;
            if (capture)
            begin
                prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
                pop_hit_q <= ~pwrite & (paddr == `OFS_RSP_DATA) &
                             (rsp_count != 16'h0000);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            len_q <= 16'h0000;
        else if (len_wr)
            len_q <= pwdata[15:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_q <= `ERR_NONE;
        else if (cmd_wr)
            err_q <= cmd_err;
        else if (data_wr & (cs_q != diag_cmd_pkg::CS_COLLECT))
            err_q <= `ERR_SEQ;
    end

    // Session, collection and transmit control.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q    <= diag_cmd_pkg::DS_NOT_INIT;
            cs_q       <= diag_cmd_pkg::CS_IDLE;
            base_q     <= 16'h0000;
            cnt_q      <= 16'h0000;
            fill_q     <= 16'h0000;
            send_q     <= 1'b0;
            mode_q     <= 8'h00;
            seg_q      <= 1'b0;
            expect_q   <= 1'b0;
            pgn_q      <= 24'h000000;
            tx_valid_q <= 1'b0;
            tx_byte_q  <= 8'h00;
            tx_last_q  <= 1'b0;
            tx_id_q    <= 29'h00000000;
            tx_idx_q   <= 16'h0000;
        end
        else
        begin
            if (state_q == diag_cmd_pkg::DS_CONNECTING)
                state_q <= diag_cmd_pkg::DS_CONNECTED;
            pgn_q <= pgn_d;
            if (cmd_ok & op_cfg)
            begin
                if (c_b1 == 8'h00)
                begin
                    state_q  <= diag_cmd_pkg::DS_NOT_INIT;
                    fill_q   <= 16'h0000;
                    expect_q <= 1'b0;
                    seg_q    <= 1'b0;
                end
                else if (state_q == diag_cmd_pkg::DS_NOT_INIT)
                    state_q <= diag_cmd_pkg::DS_NO_CONN;
            end
            else if (cmd_ok & op_start)
            begin
                state_q <= diag_cmd_pkg::DS_CONNECTING;
                mode_q  <= c_b1;
                seg_q   <= 1'b0;
                base_q  <= 16'h0000;
                cnt_q   <= 16'h0000;
                send_q  <= 1'b1;
                if (len_q != 16'h0000)
                    cs_q <= diag_cmd_pkg::CS_COLLECT;
            end
            else if (cmd_ok & op_send)
            begin
                mode_q <= c_b1;
                seg_q  <= c_seg;
                base_q <= cat_base;
                cnt_q  <= 16'h0000;
                send_q <= c_send;
                cs_q   <= diag_cmd_pkg::CS_COLLECT;
            end
            if (collect_wr)
                cnt_q <= cnt_q + 16'h0001;
            if (last_byte)
            begin
                fill_q <= new_fill;
                cs_q   <= send_q ? diag_cmd_pkg::CS_SEND :
                                   diag_cmd_pkg::CS_IDLE;
            end
            if (rsp_end)
                expect_q <= 1'b0;
            if (tx_start)
            begin
                tx_valid_q <= 1'b1;
                tx_byte_q  <= first_byte;
                tx_last_q  <= (new_fill == 16'h0001);
                tx_idx_q   <= 16'h0000;
                tx_id_q    <= id_d;
            end
            else if (tx_hs & tx_last_q)
            begin
                tx_valid_q <= 1'b0;
                tx_last_q  <= 1'b0;
                cs_q       <= diag_cmd_pkg::CS_IDLE;
                expect_q   <= ~mode_q[`NO_WAIT_BIT];
            end
            else if (tx_hs)
            begin
                tx_idx_q  <= tx_next;
                tx_byte_q <= rd_data;
                tx_last_q <= ((tx_next + 16'h0001) == fill_q);
            end
        end
    end

    // Entry bookkeeping; a new entry ending wins over the final pop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            valid_q   <= 1'b0;
            rsp_len_q <= 16'h0000;
        end
        else if (rsp_clear)
        begin
            valid_q   <= 1'b0;
            rsp_len_q <= 16'h0000;
        end
        else if (rsp_end)
        begin
            valid_q   <= 1'b1;
            rsp_len_q <= rsp_count + 16'h0001;
        end
        else if (rsp_pop & (rsp_count == 16'h0001))
            valid_q <= 1'b0;
    end

    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign tx_valid = tx_valid_q;
    assign tx_byte  = tx_byte_q;
    assign tx_last  = tx_last_q;
    assign tx_id    = tx_id_q;
endmodule : diag_request_cmd
`default_nettype wire

// File: rtl/req_store.sv
// Request buffer memory with one write port and one read port.
`default_nettype none
module req_store #(
    parameter int unsigned DEPTH = 1024,
    parameter int unsigned AW    = $clog2(DEPTH)
) (
    input  wire logic          clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data
);
    logic [7:0] mem [DEPTH];

    // Content is undefined after reset; the fill level guards every read.
    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    assign rd_data = mem[rd_addr];
endmodule : req_store
`default_nettype wire

// File: rtl/rsp_queue.sv
// Response byte queue filled from the link and drained by register reads.
`default_nettype none
module rsp_queue #(
    parameter int unsigned DEPTH = 1024,
    parameter int unsigned AW    = $clog2(DEPTH)
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clear,
    input  wire logic        push,
    input  wire logic [7:0]  push_data,
    input  wire logic        pop,
    output logic      [7:0]  head,
    output logic      [15:0] count,
    output logic             full
);
    logic [7:0]  mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    wire           do_push = push & ~full;
    wire           do_pop  = pop & (cnt_q != '0);

    always_ff @(posedge clk)
    begin
        if (do_push)
            mem[wp_q] <= push_data;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else if (clear)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (do_push)
                wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
            if (do_pop)
                rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_q + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
        end
    end

    assign head  = mem[rp_q];
    assign count = 16'(cnt_q);
    assign full  = (cnt_q == (AW+1)'(DEPTH));
endmodule : rsp_queue
`default_nettype wire

// File: shared/diag_cmd_defines.svh
// Offsets, fields, codes and limits of the diagnostic request block.
`ifndef DIAG_CMD_DEFINES_SVH
`define DIAG_CMD_DEFINES_SVH

`define OFS_CMD        8'h00
`define OFS_LEN        8'h04
`define OFS_DATA       8'h08
`define OFS_STATUS     8'h0c
`define OFS_RSP_INFO   8'h10
`define OFS_RSP_DATA   8'h14
`define OFS_CAN_ID     8'h18

`define OP_CONFIG      8'ha0
`define OP_START       8'ha1
`define OP_SEND        8'ha2
`define OP_READ        8'ha3

`define CMD_SEND_BIT   24
`define CMD_CONCAT_BIT 25
`define CMD_SEG_BIT    26
`define NO_WAIT_BIT    7

`define START_HDR      16'h0004
`define SEND_HDR       16'h0008
`define FUNC_PF_MIN    8'hf0

`define ERR_NONE       8'h00
`define ERR_BUSY       8'h01
`define ERR_CHAN       8'h02
`define ERR_SEQ        8'h03
`define ERR_LEN        8'h04
`define ERR_OVF        8'h05
`define ERR_OP         8'h06

`endif

// File: shared/diag_cmd_pkg.sv
// Types and helpers shared by the diagnostic request block.
`default_nettype none
package diag_cmd_pkg;
    typedef enum logic [2:0] {
        DS_NOT_INIT   = 3'h0,
        DS_NO_CONN    = 3'h1,
        DS_CONNECTING = 3'h2,
        DS_CONNECTED  = 3'h3,
        DS_RELEASED   = 3'h4
    } diag_state_t;

    typedef enum logic [1:0] {
        CS_IDLE    = 2'h0,
        CS_COLLECT = 2'h1,
        CS_SEND    = 2'h2
    } cmd_state_t;

    // True when len bytes written from base stay inside depth bytes.
    function automatic logic fits(input logic [15:0] base,
                                  input logic [15:0] len,
                                  input logic [16:0] depth);
        return ({1'b0, base} + {1'b0, len}) <= depth;
    endfunction : fits
endpackage : diag_cmd_pkg
`default_nettype wire

// File: tb/can_diag_request_command_bench.sv
// Self-checking bench for the diagnostic request block.
`include "diag_cmd_defines.svh"
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        checks_done++; \
        if ((got) !== (ex)) \
        begin \
            err_count++; \
            $display("unexpected %s: expected %h, seen %h", nm, ex, got); \
        end \
    end
module can_diag_request_command_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        slow = 1'b0;
    logic        reply_go = 1'b0;
    logic [7:0]  reply_n = 8'h00;
    logic [31:0] prdata, rdata;
    logic [28:0] tx_id;
    logic [7:0]  tx_byte, rx_byte;
    logic        pready, pslverr, serr, tx_valid, tx_last, tx_ready;
    logic        rx_valid, rx_last;
    int          err_count = 0;
    int          checks_done = 0;

    always #2 pclk = ~pclk;

    diag_request_cmd #(.REQ_DEPTH(16), .RSP_DEPTH(16)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_last(tx_last), .tx_id(tx_id),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_last(rx_last));
    ecu_link_model ecu (
        .pclk(pclk), .presetn(presetn), .slow(slow), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .reply_go(reply_go), .reply_n(reply_n),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_last(rx_last));

    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            err_count++;
            final_report();
        end
        rdata = prdata;
        serr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic cmd(input logic [7:0] op, input logic [7:0] ch,
                       input logic [7:0] b1, input logic [2:0] f,
                       input logic [15:0] len);
        apb(1'b1, `OFS_LEN, {16'h0000, len});
        apb(1'b1, `OFS_CMD, {5'h00, f, b1, ch, op});
    endtask : cmd

    task automatic put(input logic [7:0] b);
        apb(1'b1, `OFS_DATA, {24'h000000, b});
    endtask : put

    task automatic err_is(input logic [7:0] e);
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK("error code", e, rdata[23:16])
    endtask : err_is

    task automatic wait_tx(input int n);
        for (int k = 0; k < 400 && ecu.got.size() < n; k++)
            @(posedge pclk);
        if (ecu.got.size() < n)
        begin
            err_count++;
            final_report();
        end
    endtask : wait_tx

    task automatic reply(input logic [7:0] n);
        reply_n  <= n;
        reply_go <= 1'b1;
        @(posedge pclk);
        reply_go <= 1'b0;
        @(posedge pclk);
        for (int k = 0; k < 50 && ecu.left_q !== 8'h00; k++)
            @(posedge pclk);
        if (ecu.left_q !== 8'h00)
        begin
            err_count++;
            final_report();
        end
        repeat (3) @(posedge pclk);
    endtask : reply

    task automatic t_session();
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK("status after reset", 32'h0, rdata)
        apb(1'b0, 8'hfc, 32'h0);
        `CHK("unmapped error", 1'b1, serr)
        cmd(`OP_START, 8'h00, 8'h00, 3'h0, 16'h0000);
        err_is(`ERR_SEQ);
        cmd(`OP_CONFIG, 8'h00, 8'h01, 3'h0, 16'h0000);
        cmd(`OP_START, 8'h01, 8'h00, 3'h0, 16'h0000);
        err_is(`ERR_CHAN);
        cmd(`OP_START, 8'h00, 8'h00, 3'h0, 16'h0000);
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK("state", 3'h3, rdata[10:8])
        `CHK("start error", `ERR_NONE, rdata[23:16])
        `CHK("bytes sent", 0, ecu.got.size())
        $display("session test done");
    endtask : t_session

    task automatic t_request();
        logic [7:0] req [5] = '{8'h00, 8'hd9, 8'h00, 8'h01, 8'h15};
        slow <= 1'b1;
        cmd(`OP_SEND, 8'h00, 8'h00, 3'h0, 16'h0003);
        for (int i = 0; i < 3; i++)
            put(req[i]);
        `CHK("store only", 0, ecu.got.size())
        cmd(`OP_SEND, 8'h00, 8'h00, 3'h3, 16'h0002);
        for (int i = 3; i < 5; i++)
            put(req[i]);
        wait_tx(5);
        for (int i = 0; i < 5; i++)
            `CHK("sent byte", req[i], ecu.got[i])
        apb(1'b0, `OFS_CAN_ID, 32'h0);
        `CHK("identifier", {3'h6, 18'h0d900, 8'hf9}, rdata[28:0])
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK("busy", 1'b1, rdata[1])
        `CHK("functional", 1'b0, rdata[24])
        reply(8'h03);
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK("flags", 4'hc, rdata[3:0])
        apb(1'b0, `OFS_RSP_INFO, 32'h0);
        `CHK("response info", 32'h00030003, rdata)
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, `OFS_RSP_DATA, 32'h0);
            `CHK("response byte", 8'ha3 - i[7:0], rdata[7:0])
        end
        apb(1'b0, `OFS_RSP_INFO, 32'h0);
        `CHK("remaining", 16'h0000, rdata[31:16])
        `CHK("sent count", 5, ecu.got.size())
        $display("request test done");
    endtask : t_request

    task automatic t_limits();
        int base;
        slow <= 1'b0;
        cmd(`OP_SEND, 8'h00, 8'h00, 3'h0, 16'h0000);
        err_is(`ERR_LEN);
        cmd(`OP_SEND, 8'h00, 8'h00, 3'h0, 16'h00f9);
        err_is(`ERR_LEN);
        cmd(`OP_SEND, 8'h00, 8'h00, 3'h0, 16'h000a);
        for (int i = 0; i < 10; i++)
            put(8'hf0 + i[7:0]);
        cmd(`OP_SEND, 8'h00, 8'h00, 3'h2, 16'h0007);
        err_is(`ERR_OVF);
        `CHK("functional", 1'b1, rdata[24])
        base = ecu.got.size();
        cmd(`OP_SEND, 8'h00, 8'h80, 3'h3, 16'h0001);
        put(8'h55);
        wait_tx(base + 11);
        for (int i = 0; i < 10; i++)
            `CHK("kept byte", 8'hf0 + i[7:0], ecu.got[base + i])
        `CHK("appended byte", 8'h55, ecu.got[base + 10])
        reply(8'h02);
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK("busy", 1'b0, rdata[1])
        apb(1'b0, `OFS_RSP_INFO, 32'h0);
        `CHK("unasked response", 16'h0000, rdata[31:16])
        $display("limit test done");
    endtask : t_limits

    task automatic t_stop();
        cmd(`OP_CONFIG, 8'h00, 8'h00, 3'h0, 16'h0000);
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK("state", 3'h0, rdata[10:8])
        cmd(`OP_SEND, 8'h00, 8'h00, 3'h0, 16'h0001);
        err_is(`ERR_SEQ);
        cmd(`OP_READ, 8'h00, 8'h00, 3'h0, 16'h0000);
        err_is(`ERR_NONE);
        $display("stop test done");
    endtask : t_stop

    initial
    begin
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_session();
        t_request();
        t_limits();
        t_stop();
        final_report();
    end
endmodule : can_diag_request_command_bench
`default_nettype wire

// File: tb/diag_request_cmd_asserts.sv
// Port-level checks for the diagnostic request block.
`include "diag_cmd_defines.svh"
`default_nettype none
module diag_request_cmd_asserts #(
    parameter logic [2:0] J1939_PRIO  = 3'h6,
    parameter logic [7:0] SOURCE_ADDR = 8'hf9
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_byte,
    input wire logic        tx_last,
    input wire logic [28:0] tx_id,
    input wire logic        tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_access_wait;
        psel && penable && !pready;
    endsequence
    sequence s_byte_stalled;
        tx_valid && !tx_ready;
    endsequence
    sequence s_last_taken;
        tx_valid && tx_ready && tx_last;
    endsequence

    AST_APB_ONE_WAIT: assert property (s_access_wait |=> pready)
        else $error("access not answered after one wait state");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    AST_TX_HOLD: assert property (s_byte_stalled |=> tx_valid
        && $stable(tx_byte) && $stable(tx_last) && $stable(tx_id))
        else $error("offered byte changed before acceptance");
    AST_TX_CLOSE: assert property (s_last_taken |=> !tx_valid)
        else $error("byte offered after the final one");
    AST_TX_CONTINUE: assert property
        (tx_valid && tx_ready && !tx_last |=> tx_valid)
        else $error("request stream broken before its last byte");
    AST_TX_START: assert property ($rose(tx_valid) |->
        $past(psel) && $past(pready) && $past(pwrite) &&
        $past(paddr) == `OFS_DATA)
        else $error("transmission began without a completed data write");
    AST_ID_FIELDS: assert property (tx_valid |->
        tx_id[28:26] == J1939_PRIO && tx_id[7:0] == SOURCE_ADDR)
        else $error("identifier priority or source field wrong");
endmodule : diag_request_cmd_asserts

bind diag_request_cmd diag_request_cmd_asserts #(
    .J1939_PRIO(J1939_PRIO),
    .SOURCE_ADDR(SOURCE_ADDR)
) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
    .tx_id(tx_id), .tx_ready(tx_ready)
);
`default_nettype wire

// File: tb/ecu_link_model.sv
// Behavioural control unit at the far end of the request link.
`default_nettype none
module ecu_link_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       slow,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    input  wire logic       reply_go,
    input  wire logic [7:0] reply_n,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic      [7:0] rx_byte,
    output logic            rx_last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got [$];
    logic [7:0] left_q;
    // A slow unit accepts only on every other edge, to exercise the hold path.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            rx_byte  <= 8'h00;
            rx_last  <= 1'b0;
            left_q   <= 8'h00;
        end
        else
        begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            if (tx_valid && tx_ready)
                got.push_back(tx_byte);
            left_q   <= reply_go ? reply_n : left_q - {7'h00, left_q != 0};
            rx_valid <= left_q != 8'h00;
            rx_last  <= left_q == 8'h01;
            // An idle line must not keep showing a plausible stale byte.
            rx_byte  <= (left_q != 8'h00) ? 8'ha0 + left_q : ~rx_byte;
        end
    end
endmodule : ecu_link_model
`default_nettype wire
